// File: hw/qrs_switch_ctrl.sv
// Quasi-resonant gate control: turn-on, turn-off, foldback and burst operation
`timescale 1ns/10ps
module qrs_switch_ctrl #(
    parameter logic [63:0] FOLD_TABLE      = 64'hb8_c0_c8_d0_d8_e0_f0_ff,
    parameter int unsigned MAX_OFF_CYCLES  = qrs_pkg::MAX_OFF_CYC,
    parameter int unsigned MAX_ON_CYCLES   = qrs_pkg::MAX_ON_CYC,
    parameter int unsigned BURST_BLANK_CYC = qrs_pkg::BURST_BLANK_CYC,
    parameter int unsigned FB_SAMPLE_CYC   = qrs_pkg::FB_SAMPLE_CYC
) (
    input  wire logic                               ref_clk,
    input  wire logic                               nrst,
    input  wire qrs_pkg::qrs_cmp_t                  cmp_in,
    input  wire logic [qrs_pkg::FOLD_IDX_W-1:0]     fold_excess,
    output logic                                    gate_cmd,
    output logic [qrs_pkg::LIMIT_W-1:0]             current_limit,
    output qrs_pkg::qrs_stat_t                      status
);
    typedef enum logic [3:0] {
        QRS_OFF   = 4'b0001,
        QRS_ON    = 4'b0010,
        QRS_IDLE  = 4'b0100,
        QRS_LATCH = 4'b1000
    } qrs_state_t;

    qrs_pkg::qrs_cmp_t           cmp;
    logic [qrs_pkg::FOLD_IDX_W-1:0] fold_s;

    qrs_sync #(.W($bits(qrs_pkg::qrs_cmp_t) + qrs_pkg::FOLD_IDX_W)) u_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in ({cmp_in, fold_excess}),
        .sync_out ({cmp, fold_s})
    );

    function automatic logic [2:0] sat_inc(input logic [2:0] v);
        return (v == qrs_pkg::CNT_MAX) ? v : v + 3'h1;
    endfunction

    qrs_state_t  state_reg, state_next;
    logic [31:0] tmr_reg, tmr_next;       // Time since last gate edge
    logic [31:0] pkt_reg, pkt_next;       // Packet frequency timer
    logic [31:0] fbs_reg, fbs_next;       // Feedback sample timer
    logic [31:0] ent_reg, ent_next;       // Burst entry hold timer
    logic [7:0]  swb_reg, swb_next;       // Short-winding persistence
    logic [2:0]  valley_reg, valley_next;
    logic [2:0]  target_reg, target_next;
    logic        long_sup_reg, long_sup_next;
    logic        burst_reg, burst_next;
    logic        bias_reg, bias_next;
    logic        zl_seen_reg, zl_seen_next; // Feedback crossed ZL in sample
    logic        zh_seen_reg, zh_seen_next;
    logic        r1_seen_reg, r1_seen_next;
    logic        zc_prev_reg, zc_prev_next;
    logic        gate_reg, gate_next;
    logic [qrs_pkg::LIMIT_W-1:0] lim_reg, lim_next;

    logic [31:0] sup_cyc;
    logic        blanked, sw_hit, turn_on, turn_off, zc_edge;

    always_comb begin
        sup_cyc  = long_sup_reg ? qrs_pkg::LONG_SUPPR_CYC : qrs_pkg::SHORT_SUPPR_CYC;
        blanked  = tmr_reg < qrs_pkg::LEB_CYC;
        zc_edge  = cmp.aux_zero_fall && !zc_prev_reg;
        sw_hit   = swb_reg >= 8'(qrs_pkg::SW_BLANK_CYC);
        turn_on  = 1'b0;
        turn_off = 1'b0;
        state_next    = state_reg;
        tmr_next      = tmr_reg + 32'h1;
        pkt_next      = (pkt_reg + 32'h1 >= qrs_pkg::PACKET_PER_CYC) ? 32'h0 : pkt_reg + 32'h1;
        fbs_next      = fbs_reg + 32'h1;
        ent_next      = ent_reg;
        swb_next      = swb_reg;
        valley_next   = valley_reg;
        target_next   = target_reg;
        long_sup_next = long_sup_reg;
        burst_next    = burst_reg;
        bias_next     = bias_reg;
        zl_seen_next  = zl_seen_reg | !cmp.fb_below_zl;
        zh_seen_next  = zh_seen_reg | !cmp.fb_below_zh;
        r1_seen_next  = r1_seen_reg | cmp.fb_above_r1;
        zc_prev_next  = cmp.aux_zero_fall;
        gate_next     = gate_reg;
        lim_next      = lim_reg;

        // Short-winding blanking filter: counts only while the comparator holds
        if (cmp.short_winding && gate_reg)
            swb_next = sw_hit ? swb_reg : swb_reg + 8'h1;
        else
            swb_next = 8'h0;

        // Feedback sampling of target counter
        if (fbs_reg + 32'h1 >= FB_SAMPLE_CYC) begin
            fbs_next = 32'h0;
            // This cycle's crossing opens the next period instead of being lost
            zl_seen_next = !cmp.fb_below_zl;
            zh_seen_next = !cmp.fb_below_zh;
            r1_seen_next = cmp.fb_above_r1;
            if (r1_seen_reg)
                target_next = qrs_pkg::CNT_MIN;
            else if (zh_seen_reg)
                target_next = (target_reg == qrs_pkg::CNT_MIN) ? target_reg
                                                               : target_reg - 3'h1;
            else if (!zl_seen_reg)
                target_next = sat_inc(target_reg);
        end

        // Burst entry: conditions must hold together without a break
        if (!burst_reg && cmp.fb_below_entry && target_reg == qrs_pkg::BURST_ENTRY_CNT)
            ent_next = ent_reg + 32'h1;
        else
            ent_next = 32'h0;

        // Foldback only while the switch conducts; aux current is meaningless otherwise
        if (gate_reg && !burst_reg)
            lim_next = FOLD_TABLE[8*fold_s +: 8];

        case (state_reg)
            QRS_OFF: begin
                if (zc_edge && tmr_reg >= sup_cyc)
                    valley_next = sat_inc(valley_reg);
                if (burst_reg) begin
                    if (pkt_reg == 32'h0)
                        turn_on = 1'b1;
                end else if (tmr_reg + 32'h1 >= MAX_OFF_CYCLES) begin
                    turn_on = 1'b1;
                end else if (tmr_reg >= sup_cyc && valley_reg >= target_reg) begin
                    turn_on = 1'b1;
                end
            end
            QRS_ON: begin
                if (tmr_reg + 32'h1 >= MAX_ON_CYCLES)
                    turn_off = 1'b1;
                else if (burst_reg)
                    turn_off = pkt_reg == 32'(qrs_pkg::PACKET_ON_CYC)
                            || (!blanked && cmp.packet_current);
                else if (!blanked && (cmp.sense_over_fb || cmp.sense_over_lim))
                    turn_off = 1'b1;
                if (sw_hit && !burst_reg) begin
                    state_next = QRS_LATCH;
                    gate_next  = 1'b0;
                end
            end
            QRS_IDLE: begin
                if (cmp.fb_above_start) begin
                    bias_next  = 1'b1;
                    state_next = QRS_OFF;
                    tmr_next   = 32'h0;
                end
            end
            QRS_LATCH: begin
                gate_next = 1'b0;
            end
            default: begin
                state_next = QRS_OFF;
                gate_next  = 1'b0;
            end
        endcase

        if (turn_on) begin
            state_next  = QRS_ON;
            gate_next   = 1'b1;
            tmr_next    = 32'h0;
            valley_next = qrs_pkg::VALLEY_RESET;
        end
        if (turn_off && state_next == QRS_ON) begin
            state_next    = QRS_OFF;
            gate_next     = 1'b0;
            tmr_next      = 32'h0;
            long_sup_next = cmp.aux_low;
        end

        // Burst entry, packet stop and exit
        if (!burst_reg && ent_reg + 32'h1 >= BURST_BLANK_CYC && state_reg == QRS_OFF) begin
            burst_next = 1'b1;
            bias_next  = 1'b0;
            state_next = QRS_IDLE;
            gate_next  = 1'b0;
        end else if (burst_reg && state_reg != QRS_LATCH) begin
            if (cmp.fb_above_exit) begin
                burst_next  = 1'b0;
                bias_next   = 1'b1;
                target_next = qrs_pkg::CNT_MIN;
                lim_next    = qrs_pkg::FULL_LIMIT;
                if (state_reg == QRS_IDLE) begin
                    state_next = QRS_OFF;
                    tmr_next   = 32'h0;
                end
            end else if (cmp.fb_below_stop && state_reg != QRS_IDLE) begin
                bias_next  = 1'b0;
                state_next = QRS_IDLE;
                gate_next  = 1'b0;
                tmr_next   = 32'h0;
            end
        end
        if (burst_next)
            lim_next = qrs_pkg::FULL_LIMIT;
        if (!nrst) begin
            state_next    = QRS_OFF;
            tmr_next      = 32'h0;
            pkt_next      = 32'h0;
            fbs_next      = 32'h0;
            ent_next      = 32'h0;
            swb_next      = 8'h0;
            valley_next   = qrs_pkg::VALLEY_RESET;
            target_next   = qrs_pkg::CNT_MIN;
            long_sup_next = 1'b1;
            burst_next    = 1'b0;
            bias_next     = 1'b1;
            zl_seen_next  = 1'b0;
            zh_seen_next  = 1'b0;
            r1_seen_next  = 1'b0;
            zc_prev_next  = 1'b0;
            gate_next     = 1'b0;
            lim_next      = qrs_pkg::FULL_LIMIT;
        end
    end

    always_ff @(posedge ref_clk) begin
        state_reg    <= state_next;
        tmr_reg      <= tmr_next;
        pkt_reg      <= pkt_next;
        fbs_reg      <= fbs_next;
        ent_reg      <= ent_next;
        swb_reg      <= swb_next;
        valley_reg   <= valley_next;
        target_reg   <= target_next;
        long_sup_reg <= long_sup_next;
        burst_reg    <= burst_next;
        bias_reg     <= bias_next;
        zl_seen_reg  <= zl_seen_next;
        zh_seen_reg  <= zh_seen_next;
        r1_seen_reg  <= r1_seen_next;
        zc_prev_reg  <= zc_prev_next;
        gate_reg     <= gate_next;
        lim_reg      <= lim_next;
    end

    assign gate_cmd      = gate_reg;
    assign current_limit = lim_reg;
    assign status        = '{gate: gate_reg, bias_en: bias_reg, burst: burst_reg,
                             latched_off: state_reg == QRS_LATCH, target: target_reg};

    // Checks
    sequence gate_fall_s;
        $fell(gate_reg);
    endsequence

    suppr_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        gate_fall_s |=> !gate_reg [*8])
        else $error("gate rose inside suppression");
    leb_min_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        gate_reg && !burst_reg && tmr_reg < qrs_pkg::LEB_CYC
            |=> gate_reg || state_reg == QRS_LATCH)
        else $error("gate fell inside blanking");
    max_on_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        gate_reg |-> tmr_reg < MAX_ON_CYCLES)
        else $error("on-time exceeded");
    max_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_reg == QRS_OFF && !burst_reg |-> tmr_reg < MAX_OFF_CYCLES)
        else $error("off-time exceeded");
    target_range_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        target_reg >= qrs_pkg::CNT_MIN)
        else $error("target counter out of range");
    valley_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(gate_reg) |-> valley_reg == qrs_pkg::VALLEY_RESET)
        else $error("valley count not cleared");
    burst_exit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $fell(burst_reg) && state_reg != QRS_LATCH |-> target_reg == qrs_pkg::CNT_MIN)
        else $error("target not one after burst exit");
    latch_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_reg == QRS_LATCH |=> state_reg == QRS_LATCH && !gate_reg)
        else $error("latch released");
    idle_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_reg == QRS_IDLE |-> !gate_reg)
        else $error("gate high while idle");
    // Counted form covers the whole interval, not only its first cycles
    suppr_count_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        state_reg == QRS_OFF && !burst_reg && tmr_reg < sup_cyc |=> !gate_reg)
        else $error("gate rose before suppression ended");
    burst_entry_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(burst_reg) |-> $past(ent_reg) + 32'h1 >= BURST_BLANK_CYC)
        else $error("burst entered before hold time");
endmodule // qrs_switch_ctrl

// File: hw/qrs_pkg.sv
// Package: constants and carrier types for the quasi-resonant switch control
package qrs_pkg;

    // Clock rate in kHz
    localparam int unsigned CLK_KHZ = 250000;

    // Times as printed, in their own units
    localparam int unsigned BURST_ENTRY_BLANK_MS  = 24;
    localparam int unsigned FB_SAMPLE_MS          = 48;
    localparam int unsigned MIN_SWITCH_FREQ_KHZ   = 20;
    localparam int unsigned PACKET_PULSE_FREQ_KHZ = 52;
    localparam int unsigned PACKET_MAX_DUTY_PCT   = 50;
    localparam int unsigned SHORT_SUPPR_NS        = 1200;
    localparam int unsigned LONG_SUPPR_NS         = 3000;
    localparam int unsigned LEB_NS                = 220;
    localparam int unsigned MAX_ON_NS             = 25000;
    localparam int unsigned SHORT_WIND_BLANK_NS   = 190;

    // Derived cycle counts; least times round up, longest times round down
    localparam int unsigned SHORT_SUPPR_CYC = (SHORT_SUPPR_NS * 250 + 999) / 1000;
    localparam int unsigned LONG_SUPPR_CYC  = (LONG_SUPPR_NS * 250 + 999) / 1000;
    localparam int unsigned LEB_CYC         = (LEB_NS * 250 + 999) / 1000;
    localparam int unsigned MAX_ON_CYC      = (MAX_ON_NS * 250) / 1000;
    localparam int unsigned SW_BLANK_CYC    = (SHORT_WIND_BLANK_NS * 250 + 999) / 1000;
    localparam int unsigned MAX_OFF_CYC     = CLK_KHZ / MIN_SWITCH_FREQ_KHZ;
    localparam int unsigned PACKET_PER_CYC  = CLK_KHZ / PACKET_PULSE_FREQ_KHZ;
    localparam int unsigned PACKET_ON_CYC   = PACKET_PER_CYC * PACKET_MAX_DUTY_PCT / 100;
    localparam int unsigned BURST_BLANK_CYC = CLK_KHZ * BURST_ENTRY_BLANK_MS;
    localparam int unsigned FB_SAMPLE_CYC   = CLK_KHZ * FB_SAMPLE_MS;

    // Counter limits
    localparam logic [2:0] CNT_MIN         = 3'h1;
    localparam logic [2:0] CNT_MAX         = 3'h7;
    localparam logic [2:0] BURST_ENTRY_CNT = 3'h7;
    localparam logic [2:0] VALLEY_RESET    = 3'h0;

    // Foldback quantisation
    localparam int unsigned FOLD_IDX_W = 3;
    localparam int unsigned LIMIT_W    = 8;
    localparam logic [LIMIT_W-1:0] FULL_LIMIT = 8'hff;

    // Digitised comparator levels
    typedef struct packed {
        logic aux_low;         // Aux level below suppression_select_threshold
        logic aux_zero_fall;   // Falling zero crossing detected
        logic sense_over_fb;   // Scaled sense above feedback level
        logic sense_over_lim;  // Sense above current limit code
        logic short_winding;   // Sense above short_winding_threshold
        logic packet_current;  // Sense above packet_current_threshold
        logic fb_below_zl;     // Feedback below low counting threshold
        logic fb_below_zh;     // Feedback below high counting threshold
        logic fb_above_r1;     // Feedback above counter-reset threshold
        logic fb_below_entry;  // Feedback below burst_entry_threshold
        logic fb_above_start;  // Feedback above packet_start_threshold
        logic fb_below_stop;   // Feedback at/below packet_stop_threshold
        logic fb_above_exit;   // Feedback above burst_exit_threshold
    } qrs_cmp_t;

    typedef struct packed {
        logic       gate;
        logic       bias_en;
        logic       burst;
        logic       latched_off;
        logic [2:0] target;
    } qrs_stat_t;

endpackage

// File: hw/qrs_sync.sv
// Two-stage synchroniser for a bus of comparator levels
`timescale 1ns/10ps
module qrs_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    always_comb begin
        meta_next = nrst ? async_in : '0;
        sync_next = nrst ? meta_reg : '0;
    end

    always_ff @(posedge ref_clk) begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
    end

    assign sync_out = sync_reg;
endmodule // qrs_sync

// File: dv/qrs_sense_model.sv
// Behavioural sense comparators: primary current ramp and ringing zero crossings
`timescale 1ns/10ps
module qrs_sense_model (
    input  wire logic        ref_clk,
    input  wire logic        gate_cmd,
    input  wire logic        ring_on,
    input  wire logic [31:0] trip_cyc,
    output logic             sense_over_fb,
    output logic             aux_zero_fall
);
    int on_cnt   = 0;
    int ring_cnt = 0;

    initial begin
        sense_over_fb = 1'b0;
        aux_zero_fall = 1'b0;
    end

    always @(posedge ref_clk) begin
        // Current only flows while the switch is on, so sense drops at turn-off
        on_cnt        <= gate_cmd ? on_cnt + 1 : 0;
        sense_over_fb <= gate_cmd && (on_cnt >= trip_cyc);
        // Ringing starts at turn-off; damped tank modelled by ring_on low
        ring_cnt      <= gate_cmd ? 0 : ring_cnt + 1;
        aux_zero_fall <= !gate_cmd && ring_on && ring_cnt[2];
    end
endmodule // qrs_sense_model

// File: dv/test_quasi_resonant_switch_control.sv
// Self-checking bench for the quasi-resonant switch control
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin errors++; \
    $display("BAD %s expected %0d seen %0d", nm, ex, gt); end end
module test_quasi_resonant_switch_control;
    localparam logic [63:0] FOLD    = 64'hb8_c0_c8_d0_d8_e0_f0_ff;
    localparam int unsigned MAX_OFF = 2000;
    localparam int unsigned MAX_ON  = 3000;
    localparam int unsigned BLANK   = 200;
    localparam int unsigned SAMPLE  = 100;
    localparam int unsigned LEB     = qrs_pkg::LEB_CYC;
    localparam int unsigned PER     = qrs_pkg::PACKET_PER_CYC;
    localparam int unsigned PON     = qrs_pkg::PACKET_ON_CYC;

    logic                         ref_clk;
    logic                         nrst;
    logic                         ring_on;
    logic                         sense_over_fb;
    logic                         aux_zero_fall;
    logic                         gate_cmd;
    logic [31:0]                  trip_cyc;
    logic [2:0]                   fold_excess;
    logic [qrs_pkg::LIMIT_W-1:0]  current_limit;
    qrs_pkg::qrs_cmp_t            cmp_in;
    qrs_pkg::qrs_cmp_t            cmp_drv;
    qrs_pkg::qrs_stat_t           status;
    int                           errors = 0;
    int                           check_count = 0;
    int                           cyc;
    int                           on_t;
    int                           off_t;

    always_comb begin
        cmp_in               = cmp_drv;
        cmp_in.sense_over_fb = sense_over_fb;
        cmp_in.aux_zero_fall = aux_zero_fall;
    end

    qrs_switch_ctrl #(.FOLD_TABLE(FOLD), .MAX_OFF_CYCLES(MAX_OFF), .MAX_ON_CYCLES(MAX_ON),
        .BURST_BLANK_CYC(BLANK), .FB_SAMPLE_CYC(SAMPLE)) qrs_switch_ctrl_i (
        .ref_clk(ref_clk), .nrst(nrst), .cmp_in(cmp_in), .fold_excess(fold_excess),
        .gate_cmd(gate_cmd), .current_limit(current_limit), .status(status));

    qrs_sense_model qrs_sense_model_i (
        .ref_clk(ref_clk), .gate_cmd(gate_cmd), .ring_on(ring_on), .trip_cyc(trip_cyc),
        .sense_over_fb(sense_over_fb), .aux_zero_fall(aux_zero_fall));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Bounded wait; cyc holds the cycles spent
    task automatic wait_gate(input logic v, input int bound);
        cyc = 0;
        while (gate_cmd !== v && cyc < bound) begin
            @(posedge ref_clk);
            #1;
            cyc++;
        end
        if (gate_cmd !== v) begin
            errors++;
            $display("BAD wait_gate expected %0d seen %0d", v, gate_cmd);
            conclude();
        end
    endtask

    // Skips a partial pulse, then times one whole on and off phase
    task automatic pulse_times();
        wait_gate(1'b0, 50000);
        wait_gate(1'b1, 50000);
        wait_gate(1'b0, 50000);
        on_t = cyc;
        wait_gate(1'b1, 50000);
        off_t = cyc;
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        nrst    <= 1'b0;
        cmp_drv <= '0;
        tick(14);
        `CHK("reset_target", 3'h1, status.target)
        @(posedge ref_clk);
        nrst <= 1'b1;
        tick(1);
        `CHK("reset_gate", 1'b0, gate_cmd)
        `CHK("reset_stat_gate", 1'b0, status.gate)
        `CHK("reset_bias", 1'b1, status.bias_en)
        `CHK("reset_burst", 1'b0, status.burst)
        `CHK("reset_latch", 1'b0, status.latched_off)
        `CHK("reset_limit", 8'hff, current_limit)
        $display("test reset done");
    endtask

    task automatic t_normal();
        @(posedge ref_clk);
        ring_on <= 1'b1;
        trip_cyc <= 0;
        cmp_drv.aux_low <= 1'b1;
        pulse_times();
        `CHK("leb_on_time", 1'b1, on_t >= LEB && on_t <= LEB + 8)
        `CHK("long_off", 1'b1, off_t >= qrs_pkg::LONG_SUPPR_CYC && off_t <= 774)
        @(posedge ref_clk);
        cmp_drv.aux_low <= 1'b0;
        pulse_times();
        `CHK("short_off", 1'b1, off_t >= qrs_pkg::SHORT_SUPPR_CYC && off_t <= 324)
        $display("test normal done");
    endtask

    task automatic t_limit();
        @(posedge ref_clk);
        trip_cyc <= 100000;
        fold_excess <= 3'h3;
        cmp_drv.sense_over_lim <= 1'b1;
        pulse_times();
        `CHK("limit_on_time", 1'b1, on_t >= LEB && on_t <= LEB + 8)
        tick(20);
        `CHK("fold_limit", FOLD[31:24], current_limit)
        @(posedge ref_clk);
        cmp_drv.sense_over_lim <= 1'b0;
        $display("test limit done");
    endtask

    task automatic t_max_times();
        @(posedge ref_clk);
        ring_on <= 1'b0;
        pulse_times();
        `CHK("max_on", 1'b1, on_t >= MAX_ON - 3 && on_t <= MAX_ON + 5)
        `CHK("max_off", 1'b1, off_t >= MAX_OFF - 3 && off_t <= MAX_OFF + 5)
        @(posedge ref_clk);
        ring_on <= 1'b1;
        $display("test max_times done");
    endtask

    task automatic t_short();
        // A spike shorter than the blank time must not latch
        wait_gate(1'b1, 50000);
        tick(100);
        @(posedge ref_clk);
        cmp_drv.short_winding <= 1'b1;
        tick(qrs_pkg::SW_BLANK_CYC - 20);
        @(posedge ref_clk);
        cmp_drv.short_winding <= 1'b0;
        tick(10);
        `CHK("spike_no_latch", 1'b0, status.latched_off)
        wait_gate(1'b0, 50000);
        wait_gate(1'b1, 50000);
        tick(100);
        @(posedge ref_clk);
        cmp_drv.short_winding <= 1'b1;
        tick(qrs_pkg::SW_BLANK_CYC + 10);
        `CHK("sw_latch", 1'b1, status.latched_off)
        `CHK("sw_gate_off", 1'b0, gate_cmd)
        @(posedge ref_clk);
        cmp_drv.short_winding <= 1'b0;
        tick(3 * MAX_OFF);
        `CHK("latch_holds", 1'b0, gate_cmd)
        $display("test short done");
    endtask

    task automatic t_burst();
        @(posedge ref_clk);
        trip_cyc <= 0;
        cmp_drv.fb_below_zl <= 1'b1;
        cmp_drv.fb_below_zh <= 1'b1;
        tick(10 * SAMPLE);
        `CHK("target_sat", 3'h7, status.target)
        @(posedge ref_clk);
        cmp_drv.fb_below_zl <= 1'b0;
        cmp_drv.fb_below_zh <= 1'b0;
        cmp_drv.fb_above_r1 <= 1'b1;
        tick(2 * SAMPLE);
        `CHK("target_r1", 3'h1, status.target)
        @(posedge ref_clk);
        cmp_drv.fb_below_zl <= 1'b1;
        cmp_drv.fb_below_zh <= 1'b1;
        cmp_drv.fb_above_r1 <= 1'b0;
        tick(10 * SAMPLE);
        `CHK("target_resat", 3'h7, status.target)
        // Start the hold at a turn-on so that it runs out in an off phase
        wait_gate(1'b0, 50000);
        wait_gate(1'b1, 50000);
        @(posedge ref_clk);
        cmp_drv.fb_below_entry <= 1'b1;
        tick(150);
        `CHK("burst_early", 1'b0, status.burst)
        tick(100);
        `CHK("burst_entry", 1'b1, status.burst)
        tick(3 * MAX_OFF);
        `CHK("burst_idle", 1'b0, gate_cmd)
        @(posedge ref_clk);
        cmp_drv.fb_below_entry <= 1'b0;
        cmp_drv.fb_above_start <= 1'b1;
        trip_cyc <= 100000;
        tick(10);
        `CHK("packet_bias", 1'b1, status.bias_en)
        @(posedge ref_clk);
        cmp_drv.fb_above_start <= 1'b0;
        pulse_times();
        `CHK("packet_duty", 1'b1, on_t >= PON - 2 && on_t <= PON + 2)
        `CHK("packet_period", 1'b1, on_t + off_t >= PER - 2 && on_t + off_t <= PER + 2)
        @(posedge ref_clk);
        cmp_drv.packet_current <= 1'b1;
        pulse_times();
        `CHK("packet_cs_stop", 1'b1, on_t < PON / 2)
        `CHK("packet_cs_period", 1'b1, on_t + off_t >= PER - 2 && on_t + off_t <= PER + 2)
        @(posedge ref_clk);
        cmp_drv.packet_current <= 1'b0;
        cmp_drv.fb_below_stop <= 1'b1;
        tick(10);
        `CHK("stop_bias", 1'b0, status.bias_en)
        tick(2 * PER);
        `CHK("stop_idle", 1'b0, gate_cmd)
        @(posedge ref_clk);
        cmp_drv <= '0;
        @(posedge ref_clk);
        cmp_drv.fb_above_exit <= 1'b1;
        tick(10);
        `CHK("exit_burst", 1'b0, status.burst)
        `CHK("exit_target", 3'h1, status.target)
        `CHK("exit_limit", 8'hff, current_limit)
        $display("test burst done");
    endtask

    initial begin
        nrst        = 1'b0;
        cmp_drv     = '0;
        ring_on     = 1'b0;
        trip_cyc    = 0;
        fold_excess = 3'h0;
        do_reset();
        t_normal();
        t_limit();
        t_max_times();
        t_short();
        do_reset();
        t_burst();
        conclude();
    end
endmodule // test_quasi_resonant_switch_control
